//--- inc/pbsp_pkg.sv
package pbsp_pkg;
   // bus widths of the memory
   localparam int PBSP_ADDR_W = 17;
   localparam int PBSP_DATA_W = 36;
   localparam int PBSP_LANES = 4;
   // clock period, sleep timing, counter zero and burst beat limit
   localparam int PBSP_CLK_NS = 10;
   localparam int PBSP_SLEEP_ENTRY_CYC = 2;
   localparam int PBSP_SLEEP_RECOVERY_CYC = 2;
   localparam int PBSP_SLEEP_RECOVERY_NS = PBSP_SLEEP_RECOVERY_CYC * PBSP_CLK_NS;
   localparam int PBSP_RECOV_CNT = (PBSP_SLEEP_RECOVERY_NS + PBSP_CLK_NS - 1) / PBSP_CLK_NS;
   localparam int PBSP_ENTRY_CNT = PBSP_SLEEP_ENTRY_CYC;
   localparam logic [2:0] PBSP_CNT_ZERO = 3'h0;
   localparam logic [1:0] PBSP_BEATS_MAX = 2'h3;

   // user command codes
   typedef enum logic [1:0] {
      PBSP_CMD_READ = 2'h0,
      PBSP_CMD_WRITE = 2'h1,
      PBSP_CMD_BURST = 2'h2,
      PBSP_CMD_NOP = 2'h3
   } pbsp_cmd_t;

   // sleep sequencing states, gray along the usual path
   typedef enum logic [1:0] {
      PBSP_ST_RUN = 2'h0,
      PBSP_ST_DRAIN = 2'h1,
      PBSP_ST_SLEEP = 2'h3,
      PBSP_ST_RECOVER = 2'h2
   } pbsp_state_t;

   // one user request
   typedef struct packed {
      pbsp_cmd_t cmd;
      logic [PBSP_ADDR_W-1:0] addr;
      logic [PBSP_DATA_W-1:0] wdata;
      logic [PBSP_LANES-1:0] lane_en;
   } pbsp_req_t;

   // pins driven toward the memory, one cycle's worth
   typedef struct packed {
      logic clock_qualify_n;
      logic chip_select_first_n;
      logic chip_select_second;
      logic chip_select_third_n;
      logic advance_load;
      logic write_strobe_n;
      logic [PBSP_LANES-1:0] byte_lane_write_n;
      logic [PBSP_ADDR_W-1:0] addr;
   } pbsp_pins_t;
endpackage : pbsp_pkg

//--- verilog/pbsp_ctrl.sv
`timescale 1ns/1ns
module pbsp_ctrl
   import pbsp_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic req_valid_in,
   input wire pbsp_req_t req_in,
   input wire logic stall_in,
   input wire logic sleep_in,
   input wire logic burst_order_in,
   output logic req_ready_out,
   output logic rdata_valid_out,
   output logic [PBSP_DATA_W-1:0] rdata_out,
   output logic sleeping_out,
   output pbsp_pins_t pins_out,
   output logic output_drive_n_out,
   output logic sleep_request_out,
   output logic burst_order_out,
   input wire logic [PBSP_DATA_W-1:0] data_pins_in,
   output logic [PBSP_DATA_W-1:0] data_pins_out,
   output logic data_pins_oe_n_out
);

   // ***************************************************************
   // helpers
   // ***************************************************************
   // build pin set for an op; deselect keeps cs inactive
   function automatic pbsp_pins_t pbsp_mk_pins(input logic sel, input logic adv,
         input logic wr, input logic [PBSP_LANES-1:0] ln, input logic [PBSP_ADDR_W-1:0] a);
      pbsp_pins_t p;
      p.clock_qualify_n = 1'b0;
      p.chip_select_first_n = ~sel;
      p.chip_select_second = sel;
      p.chip_select_third_n = ~sel;
      p.advance_load = adv;
      p.write_strobe_n = ~wr;
      p.byte_lane_write_n = wr ? ~ln : {PBSP_LANES{1'b1}};
      p.addr = a;
      return p;
   endfunction : pbsp_mk_pins

   // ***************************************************************
   // state
   // ***************************************************************
   pbsp_state_t state;
   pbsp_state_t next_state;
   logic [2:0] cnt;
   logic burst_open;
   logic burst_wr;
   logic [1:0] beats;
   logic rd_p1;
   logic rd_p2;
   logic rd_p3;
   logic wr_p1;
   logic wr_p2;
   logic [PBSP_DATA_W-1:0] wd_p1;
   logic [PBSP_DATA_W-1:0] wd_p2;
   logic take;
   logic is_burst;
   logic can_burst;
   logic sleep_go;
   logic mem_adv;

   // commands are taken only in run state and when the memory is not stalled
   assign can_burst = burst_open && (beats != PBSP_BEATS_MAX);
   assign is_burst = req_in.cmd == PBSP_CMD_BURST;
   assign take = req_valid_in && !stall_in && (state == PBSP_ST_RUN) && !sleep_in
      && (!is_burst || can_burst);
   // no access may still be in flight when sleep starts, it would be lost
   assign sleep_go = sleep_in && !rd_p1 && !rd_p2 && !rd_p3
      && !wr_p1 && !wr_p2;
   // the memory steps only on edges whose registered qualifier is low, so the
   // data side of the pipe follows the pins and runs one edge behind stall_in
   assign mem_adv = !pins_out.clock_qualify_n;

   // ***************************************************************
   // sleep sequencer
   // ***************************************************************
   // drain the pipeline deselected before sleep, hold selects off after
   always_comb begin
      next_state = state;
      case (state)
         PBSP_ST_RUN: begin
            if (sleep_go && !stall_in) next_state = PBSP_ST_DRAIN;
         end
         PBSP_ST_DRAIN: begin
            if (cnt == 3'(PBSP_ENTRY_CNT - 1)) next_state = PBSP_ST_SLEEP;
         end
         PBSP_ST_SLEEP: begin
            if (!sleep_in) next_state = PBSP_ST_RECOVER;
         end
         PBSP_ST_RECOVER: begin
            if (cnt == 3'(PBSP_RECOV_CNT - 1)) next_state = PBSP_ST_RUN;
         end
         default: next_state = PBSP_ST_RUN;
      endcase
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         state <= PBSP_ST_RUN;
         cnt <= PBSP_CNT_ZERO;
      end else begin
         state <= next_state;
         cnt <= (next_state != state) ? PBSP_CNT_ZERO : cnt + 3'h1;
      end
   end

   // sleep request and status flags
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         sleep_request_out <= 1'b0;
         sleeping_out <= 1'b0;
      end else begin
         sleep_request_out <= (next_state == PBSP_ST_SLEEP);
         sleeping_out <= (next_state != PBSP_ST_RUN);
      end
   end

   // ***************************************************************
   // command issue
   // ***************************************************************
   // one command per clock; a stall freezes the memory and our pipe alike
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         pins_out <= pbsp_mk_pins(1'b0, 1'b0, 1'b0, '0, '0);
         burst_open <= 1'b0;
         burst_wr <= 1'b0;
         beats <= 2'h0;
         burst_order_out <= 1'b0;
      end else begin
         burst_order_out <= burst_order_in;
         if (stall_in) begin
            pins_out.clock_qualify_n <= 1'b1;
         end else if (take && is_burst) begin
            // selects and strobe ignored, lanes resent per beat
            pins_out <= pbsp_mk_pins(1'b0, 1'b1, burst_wr, req_in.lane_en, '0);
            beats <= beats + 2'h1;
         end else if (take && req_in.cmd != PBSP_CMD_NOP) begin
            pins_out <= pbsp_mk_pins(1'b1, 1'b0, req_in.cmd == PBSP_CMD_WRITE,
               req_in.lane_en, req_in.addr);
            burst_open <= 1'b1;
            burst_wr <= req_in.cmd == PBSP_CMD_WRITE;
            beats <= 2'h0;
         end else begin
            // deselect with a fresh load closes any burst
            pins_out <= pbsp_mk_pins(1'b0, 1'b0, 1'b0, '0, '0);
            burst_open <= 1'b0;
            beats <= 2'h0;
         end
      end
   end

   // ready is registered; a burst beat may still be refused via take
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) req_ready_out <= 1'b0;
      else req_ready_out <= (next_state == PBSP_ST_RUN) && !sleep_in;
   end

   // ***************************************************************
   // data pipeline
   // ***************************************************************
   // stage 1 follows the pins, stage 2 the memory's command edge,
   // stage 3 the edge at which the memory launches read data
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         rd_p1 <= 1'b0;
         rd_p2 <= 1'b0;
         rd_p3 <= 1'b0;
         wr_p1 <= 1'b0;
         wr_p2 <= 1'b0;
         wd_p1 <= '0;
         wd_p2 <= '0;
      end else begin
         if (!stall_in) begin
            rd_p1 <= take && (is_burst ? !burst_wr : req_in.cmd == PBSP_CMD_READ);
            wr_p1 <= take && (is_burst ? burst_wr : req_in.cmd == PBSP_CMD_WRITE);
            wd_p1 <= req_in.wdata;
         end
         if (mem_adv) begin
            rd_p2 <= rd_p1;
            rd_p3 <= rd_p2;
            wr_p2 <= wr_p1;
            wd_p2 <= wd_p1;
         end
      end
   end

   // drive write data only in the data phase; the output drive opens only
   // while the memory launches read data, so the two never overlap
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         data_pins_out <= '0;
         data_pins_oe_n_out <= 1'b1;
         output_drive_n_out <= 1'b1;
      end else if (mem_adv) begin
         data_pins_out <= wd_p2;
         data_pins_oe_n_out <= ~wr_p2;
         output_drive_n_out <= ~rd_p2;
      end
   end

   // capture read data one memory edge after the memory launched it
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         rdata_out <= '0;
         rdata_valid_out <= 1'b0;
      end else begin
         rdata_valid_out <= mem_adv && rd_p3;
         if (mem_adv && rd_p3) rdata_out <= data_pins_in;
      end
   end

   // ***************************************************************
   // checks
   // ***************************************************************
   default clocking pbsp_cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);

   AST_WR_DATA_TWO: assert property ((take && !is_burst && req_in.cmd == PBSP_CMD_WRITE
      && !stall_in) ##1 !stall_in ##1 !stall_in |=> !data_pins_oe_n_out)
      else $error("write data not driven two edges after command");
   AST_NO_FIGHT: assert property (!data_pins_oe_n_out |-> output_drive_n_out)
      else $error("data driven while memory output enabled");
   AST_STALL_QUAL: assert property (stall_in |=> pins_out.clock_qualify_n)
      else $error("stall not shown on clock qualifier");
   AST_SLEEP_DESEL: assert property ($rose(sleep_request_out)
      |-> pins_out.chip_select_second == 1'b0)
      else $error("sleep raised while selected");
   AST_RECOVER_DESEL: assert property ((state == PBSP_ST_RECOVER) |=>
      !pins_out.chip_select_second)
      else $error("selected during recovery");
   AST_BURST_LIMIT: assert property (pins_out.advance_load |-> beats != 2'h0)
      else $error("burst beat without loaded address");
   AST_BURST_DIR: assert property (pins_out.advance_load && !pins_out.clock_qualify_n
      |-> pins_out.write_strobe_n == !burst_wr)
      else $error("burst direction changed");
   AST_READ_RET: assert property ((rd_p1 && !stall_in) ##1 !stall_in ##1 !stall_in
      |=> rdata_valid_out)
      else $error("read data not returned");
   AST_SLEEP_ENTRY: assert property ($rose(state == PBSP_ST_DRAIN) |-> ##2
      state == PBSP_ST_SLEEP)
      else $error("sleep entry not two cycles");
   COV_READ: cover property (rdata_valid_out);
   COV_WRITE: cover property (!data_pins_oe_n_out);
   COV_BURST4: cover property (beats == PBSP_BEATS_MAX);
   // load cycles must carry the request exactly as it was taken
   AST_LOAD_RD: assert property ((take && !is_burst && req_in.cmd == PBSP_CMD_READ)
      |=> pins_out.chip_select_second && pins_out.write_strobe_n && !pins_out.advance_load
      && pins_out.addr == $past(req_in.addr))
      else $error("read load cycle malformed");
   AST_LOAD_WR: assert property ((take && !is_burst && req_in.cmd == PBSP_CMD_WRITE)
      |=> pins_out.chip_select_second && !pins_out.write_strobe_n && !pins_out.advance_load
      && pins_out.byte_lane_write_n == ~$past(req_in.lane_en))
      else $error("write load cycle malformed");
   AST_BURST_LANES: assert property ((take && is_burst && burst_wr)
      |=> pins_out.byte_lane_write_n == ~$past(req_in.lane_en))
      else $error("burst beat lanes not resent");
   // the drive window must follow the memory, frozen edges included
   AST_ODRV_WINDOW: assert property ((rd_p2 && mem_adv) |=> !output_drive_n_out)
      else $error("output drive not opened for read data");
   AST_FROZEN_HOLD: assert property (!mem_adv
      |=> $stable(output_drive_n_out) && $stable(data_pins_oe_n_out))
      else $error("data side moved on an ignored edge");
   AST_RD_CAPTURE: assert property (rdata_valid_out |-> !$past(output_drive_n_out))
      else $error("read data taken with output drive closed");
   AST_DRAIN_DESEL: assert property ((state == PBSP_ST_DRAIN)
      |=> !pins_out.chip_select_second)
      else $error("selected while draining for sleep");
   COV_SLEEP: cover property (state == PBSP_ST_RECOVER ##1 state == PBSP_ST_RUN);
   COV_STALL: cover property (stall_in ##1 stall_in ##1 !stall_in);
endmodule : pbsp_ctrl

//--- testbench/pbsp_sram_model.sv
`timescale 1ns/1ns
module pbsp_sram_model
   import pbsp_pkg::*;
(
   input wire logic clk_sys_in,
   input wire pbsp_pins_t pins_in,
   input wire logic output_drive_n_in,
   input wire logic sleep_request_in,
   input wire logic burst_order_in,
   input wire logic [PBSP_DATA_W-1:0] bus_in,
   input wire logic ctrl_drive_in,
   output logic [PBSP_DATA_W-1:0] q_out,
   output logic drive_out,
   output logic viol_out
);
   // ********
   // memory
   // ********
   logic [PBSP_DATA_W-1:0] mem [0:(1<<PBSP_ADDR_W)-1];
   logic [PBSP_ADDR_W-1:0] base, bb, ba, ra, wa, wa2;
   logic [1:0] cnt, n;
   logic [PBSP_LANES-1:0] wl, wl2;
   logic act = 1'b0, rd1 = 1'b0, w1 = 1'b0, w2 = 1'b0, q_en = 1'b0;
   logic dir_rd, sel, load, bact, brd, slp_d = 1'b0;
   int recov = 0;
   // start from a known array so partial lane writes compare without unknowns
   initial begin
      viol_out = 1'b0;
      for (int i = 0; i < (1 << PBSP_ADDR_W); i++) mem[i] = '0;
   end
   // beat decode: a load uses the pins, a step reuses the latched burst
   assign sel = !pins_in.chip_select_first_n && pins_in.chip_select_second
      && !pins_in.chip_select_third_n;
   assign load = !pins_in.advance_load;
   assign n = load ? 2'h0 : cnt + 2'h1;
   assign bact = load ? sel : act;
   assign brd = load ? pins_in.write_strobe_n : dir_rd;
   assign bb = load ? pins_in.addr : base;
   assign ba = {bb[PBSP_ADDR_W-1:2], burst_order_in ? bb[1:0] ^ n : bb[1:0] + n};
   // output enable is asynchronous, so it gates the registered enable
   assign drive_out = q_en && !output_drive_n_in;
   // pipeline; pending work is dropped on sleep, contents kept
   always @(posedge clk_sys_in) begin
      if (sleep_request_in) begin
         rd1 <= 1'b0;
         w1 <= 1'b0;
         w2 <= 1'b0;
         q_en <= 1'b0;
      end else if (!pins_in.clock_qualify_n) begin
         if (load) begin
            act <= sel;
            dir_rd <= pins_in.write_strobe_n;
            base <= pins_in.addr;
         end
         cnt <= n;
         rd1 <= bact && brd;
         w1 <= bact && !brd;
         ra <= ba;
         wa <= ba;
         wl <= pins_in.byte_lane_write_n;
         q_en <= rd1;
         q_out <= mem[ra];
         w2 <= w1;
         wa2 <= wa;
         wl2 <= wl;
         for (int k = 0; k < PBSP_LANES; k++) begin
            if (w2 && !wl2[k]) mem[wa2][9*k+:9] <= bus_in[9*k+:9];
         end
      end
   end
   // controller hazards are only flagged; the bench reads the flag
   always @(posedge clk_sys_in) begin
      slp_d <= sleep_request_in;
      if (slp_d && !sleep_request_in) recov <= PBSP_SLEEP_RECOVERY_CYC;
      else if (recov > 0) recov <= recov - 1;
      if (ctrl_drive_in && drive_out) viol_out <= 1'b1;
      if (sleep_request_in && !slp_d && act) viol_out <= 1'b1;
      if ((recov > 0 || sleep_request_in) && sel && load) viol_out <= 1'b1;
   end
endmodule : pbsp_sram_model

//--- testbench/test_pipelined_burst_sram_port.sv
`timescale 1ns/1ns
module test_pipelined_burst_sram_port;
   import pbsp_pkg::*;
   logic clk_sys_in = 1'b0, rst_n_in = 1'b0, req_valid_in = 1'b0, stall_in = 1'b0;
   logic sleep_in = 1'b0, burst_order_in = 1'b0, tick = 1'b0;
   pbsp_req_t req_in = '0;
   logic req_ready_out, rdata_valid_out, sleeping_out, output_drive_n_out;
   logic sleep_request_out, burst_order_out, data_pins_oe_n_out, m_drv, m_viol;
   logic [PBSP_DATA_W-1:0] rdata_out, data_pins_out, m_q, bus;
   pbsp_pins_t pins_out;
   logic [PBSP_DATA_W-1:0] ref_mem [int];
   logic [PBSP_DATA_W-1:0] rq [$], eq [$];
   int n_mismatch = 0, samples_checked = 0;
   // clock and released-bus pattern, which moves so no stale word passes
   always #5 clk_sys_in = ~clk_sys_in;
   always @(posedge clk_sys_in) tick <= ~tick;
   assign bus = !data_pins_oe_n_out ? data_pins_out : m_drv ? m_q
      : (tick ? 36'hA5A5A5A5A : 36'h5A5A5A5A5);
   // collect returned words
   always @(posedge clk_sys_in) if (rdata_valid_out === 1'b1) rq.push_back(rdata_out);
   pbsp_ctrl dut_u (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
      .req_valid_in(req_valid_in), .req_in(req_in), .stall_in(stall_in),
      .sleep_in(sleep_in), .burst_order_in(burst_order_in), .req_ready_out(req_ready_out),
      .rdata_valid_out(rdata_valid_out), .rdata_out(rdata_out), .sleeping_out(sleeping_out),
      .pins_out(pins_out), .output_drive_n_out(output_drive_n_out),
      .sleep_request_out(sleep_request_out), .burst_order_out(burst_order_out),
      .data_pins_in(bus), .data_pins_out(data_pins_out),
      .data_pins_oe_n_out(data_pins_oe_n_out));
   pbsp_sram_model mdl_u (.clk_sys_in(clk_sys_in), .pins_in(pins_out),
      .output_drive_n_in(output_drive_n_out), .sleep_request_in(sleep_request_out),
      .burst_order_in(burst_order_out), .bus_in(bus), .ctrl_drive_in(!data_pins_oe_n_out),
      .q_out(m_q), .drive_out(m_drv), .viol_out(m_viol));
   task automatic conclude;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : conclude
   task automatic chk(input logic [PBSP_DATA_W-1:0] got, input logic [PBSP_DATA_W-1:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // ********
   // drivers
   // ********
   task automatic issue(input pbsp_cmd_t c, input logic [PBSP_ADDR_W-1:0] a,
         input logic [PBSP_DATA_W-1:0] d, input logic [PBSP_LANES-1:0] l);
      int i;
      @(negedge clk_sys_in);
      req_valid_in = 1'b1;
      req_in = '{c, a, d, l};
      for (i = 0; i < 50; i++) begin
         @(posedge clk_sys_in);
         if (req_ready_out === 1'b1 && !stall_in) break;
      end
      if (i == 50) begin
         n_mismatch++;
         conclude();
      end
   endtask : issue
   task automatic wr(input pbsp_cmd_t c, input logic [PBSP_ADDR_W-1:0] a,
         input logic [PBSP_DATA_W-1:0] d, input logic [PBSP_LANES-1:0] l);
      logic [PBSP_DATA_W-1:0] w;
      w = ref_mem.exists(a) ? ref_mem[a] : '0;
      for (int k = 0; k < PBSP_LANES; k++) if (l[k]) w[9*k+:9] = d[9*k+:9];
      ref_mem[a] = w;
      issue(c, a, d, l);
   endtask : wr
   task automatic rd(input pbsp_cmd_t c, input logic [PBSP_ADDR_W-1:0] a);
      eq.push_back(ref_mem[a]);
      issue(c, a, '0, '0);
   endtask : rd
   // bounded wait for every read, then compare in order
   task automatic drain;
      @(negedge clk_sys_in);
      req_valid_in = 1'b0;
      for (int i = 0; i < 30 && rq.size() < eq.size(); i++) @(negedge clk_sys_in);
      chk(36'(rq.size()), 36'(eq.size()));
      if (rq.size() < eq.size()) conclude();
      while (eq.size() > 0 && rq.size() > 0) chk(rq.pop_front(), eq.pop_front());
      eq.delete();
      rq.delete();
   endtask : drain
   function automatic logic [PBSP_ADDR_W-1:0] beat(input logic [PBSP_ADDR_W-1:0] a,
         input logic [1:0] n, input logic o);
      return {a[PBSP_ADDR_W-1:2], o ? a[1:0] ^ n : a[1:0] + n};
   endfunction : beat
   // **********
   // scenarios
   // **********
   task automatic s_reset;
      chk(36'(!pins_out.chip_select_first_n && pins_out.chip_select_second
         && !pins_out.chip_select_third_n), 36'h0);
      chk(36'({data_pins_oe_n_out, output_drive_n_out}), 36'h3);
   endtask : s_reset
   task automatic s_rw;
      wr(PBSP_CMD_WRITE, 17'h00010, 36'h123456789, 4'hF);
      wr(PBSP_CMD_WRITE, 17'h00020, 36'h0FEDCBA98, 4'hF);
      rd(PBSP_CMD_READ, 17'h00010);
      wr(PBSP_CMD_WRITE, 17'h00010, 36'hFEDCBA987, 4'h5);
      rd(PBSP_CMD_READ, 17'h00020);
      wr(PBSP_CMD_WRITE, 17'h00020, 36'h555AAA333, 4'hA);
      rd(PBSP_CMD_READ, 17'h00010);
      rd(PBSP_CMD_READ, 17'h00020);
      drain();
   endtask : s_rw
   task automatic s_burst(input logic o, input logic [PBSP_ADDR_W-1:0] a);
      logic [PBSP_LANES-1:0] ln [4] = '{4'hF, 4'hF, 4'h6, 4'hF};
      @(negedge clk_sys_in);
      burst_order_in = o;
      for (int n = 0; n < 4; n++) wr(n ? PBSP_CMD_BURST : PBSP_CMD_WRITE, beat(a, 2'(n), o),
         {9'(9'h1A0 + n), 27'h2C3D4E5}, ln[n]);
      for (int n = 0; n < 4; n++) rd(n ? PBSP_CMD_BURST : PBSP_CMD_READ,
         beat(a, 2'(n), o));
      drain();
   endtask : s_burst
   task automatic s_stall;
      wr(PBSP_CMD_WRITE, 17'h00050, 36'h9ABCDEF01, 4'hF);
      wr(PBSP_CMD_WRITE, 17'h00051, 36'h0, 4'hF);
      rd(PBSP_CMD_READ, 17'h00050);
      @(negedge clk_sys_in);
      req_valid_in = 1'b0;
      stall_in = 1'b1;
      repeat (3) @(negedge clk_sys_in);
      stall_in = 1'b0;
      drain();
   endtask : s_stall
   task automatic s_sleep;
      wr(PBSP_CMD_WRITE, 17'h00060, 36'h3C3C3C3C3, 4'hF);
      drain();
      sleep_in = 1'b1;
      for (int i = 0; i < 40 && sleep_request_out !== 1'b1; i++) @(negedge clk_sys_in);
      chk(36'({sleep_request_out, sleeping_out}), 36'h3);
      if (sleep_request_out !== 1'b1) conclude();
      repeat (4) @(negedge clk_sys_in);
      sleep_in = 1'b0;
      for (int i = 0; i < 40 && req_ready_out !== 1'b1; i++) @(negedge clk_sys_in);
      if (req_ready_out !== 1'b1) begin
         n_mismatch++;
         conclude();
      end
      rd(PBSP_CMD_READ, 17'h00060);
      drain();
   endtask : s_sleep
   // main sequence
   initial begin
      repeat (10) @(negedge clk_sys_in);
      s_reset();
      rst_n_in = 1'b1;
      s_rw();
      s_burst(1'b0, 17'h00041);
      s_burst(1'b1, 17'h00081);
      s_stall();
      s_sleep();
      chk(36'(m_viol), 36'h0);
      conclude();
   end
endmodule : test_pipelined_burst_sram_port
